// ### rtl/soswt_pkg.sv
package soswt_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int DEADLINE_US = 400;
	// longest time, rounded down
	localparam int DEADLINE_CYC = (DEADLINE_US * (CLK_HZ / 1_000_000));
	localparam int TEST_PERIOD_CYC = 50_000;
	localparam int CNT_W = 20;
	localparam int NUM_OUT = 4;
	typedef enum logic [1:0] {
		SOSWT_RUN,
		SOSWT_TEST,
		SOSWT_ALARM
	} soswt_state_t;
endpackage

// ### rtl/soswt_top.sv
`timescale 1ns/1ps
// Operation
// - periodically switch each requested-on output off in turn (already-off outputs are skipped), sample readback
// - pass only when readback shows at-or-below level
// - deadline timer starts when output disabled
// - on pass, record and re-enable immediately
// - deadline miss: alarm, all outputs off
// - other channel reads back every output state
module soswt_top #(
	parameter int NUM_OUT = soswt_pkg::NUM_OUT,
	parameter int TEST_PERIOD_CYC = soswt_pkg::TEST_PERIOD_CYC,
	parameter int DEADLINE_CYC = soswt_pkg::DEADLINE_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// demanded output states
	input wire logic [NUM_OUT-1:0] out_req_in,
	// comparator: 1 = output at or below pass level
	input wire logic [NUM_OUT-1:0] low_level_in,
	// second channel alarm input
	input wire logic peer_alarm_in,
	// drives to outputs
	output logic [NUM_OUT-1:0] out_en_out,
	// readback for the complementary channel
	output logic [NUM_OUT-1:0] xreadback_out,
	// status
	output logic alarm_out,
	output logic test_pass_out,
	output logic test_active_out
);
	localparam int IDX_W = (NUM_OUT > 1) ? $clog2(NUM_OUT) : 1;

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	soswt_pkg::soswt_state_t state_r, state_nxt;
	logic [soswt_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic [NUM_OUT-1:0] en_r, en_nxt;
	logic [NUM_OUT-1:0] rb_r, rb_nxt;
	logic alarm_r, alarm_nxt;
	logic pass_r, pass_nxt;
	logic act_r, act_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		pass_nxt = 1'b0;
		alarm_nxt = alarm_r;
		en_nxt = out_req_in;
		// cross-channel copy of what is actually being driven
		rb_nxt = en_r;
		case (state_r)
			soswt_pkg::SOSWT_RUN: begin
				// fixed interval between tests
				if (cnt_r >= soswt_pkg::CNT_W'(TEST_PERIOD_CYC - 1)) begin
					cnt_nxt = '0;
					// an output that is already off needs no proof
					if (out_req_in[idx_r]) begin
						state_nxt = soswt_pkg::SOSWT_TEST;
						en_nxt[idx_r] = 1'b0;
					end else begin
						idx_nxt = (idx_r == IDX_W'(NUM_OUT - 1)) ? '0 :
							idx_r + 1'b1;
					end
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			soswt_pkg::SOSWT_TEST: begin
				en_nxt[idx_r] = 1'b0;
				cnt_nxt = cnt_r + 1'b1;
				if (low_level_in[idx_r]) begin
					// re-enable at once, no wait for the deadline
					state_nxt = soswt_pkg::SOSWT_RUN;
					en_nxt[idx_r] = out_req_in[idx_r];
					pass_nxt = 1'b1;
					cnt_nxt = '0;
					idx_nxt = (idx_r == IDX_W'(NUM_OUT - 1)) ? '0 :
						idx_r + 1'b1;
				end else if (cnt_r >= soswt_pkg::CNT_W'(DEADLINE_CYC - 1)) begin
					state_nxt = soswt_pkg::SOSWT_ALARM;
					alarm_nxt = 1'b1;
				end
			end
			default: begin
				alarm_nxt = 1'b1;
			end
		endcase
		// alarm latches: only reset leaves it
		if (peer_alarm_in && !alarm_r) begin
			state_nxt = soswt_pkg::SOSWT_ALARM;
			alarm_nxt = 1'b1;
		end
		if (alarm_nxt) begin
			en_nxt = '0;
			// no pass pulse once shut down: outputs stay off
			pass_nxt = 1'b0;
		end
		act_nxt = (state_nxt == soswt_pkg::SOSWT_TEST);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= soswt_pkg::SOSWT_RUN;
			cnt_r <= '0;
			idx_r <= '0;
			en_r <= '0;
			rb_r <= '0;
			alarm_r <= 1'b0;
			pass_r <= 1'b0;
			act_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			en_r <= en_nxt;
			rb_r <= rb_nxt;
			alarm_r <= alarm_nxt;
			pass_r <= pass_nxt;
			act_r <= act_nxt;
		end
	end

	assign out_en_out = en_r;
	assign xreadback_out = rb_r;
	assign alarm_out = alarm_r;
	assign test_pass_out = pass_r;
	assign test_active_out = act_r;
endmodule // soswt_top

// ### dv/soswt_load.sv
`timescale 1ns/1ps
module soswt_load (
	input wire logic clk_in,
	input wire logic [3:0] en_in,
	input wire logic stuck_in,
	output logic [3:0] low_out
);
	logic [3:0] h_r;
	always_ff @(posedge clk_in) h_r <= ~en_in;
	// one cycle of discharge; stuck never reaches the level
	assign low_out = h_r & ~en_in & {4{!stuck_in}};
endmodule // soswt_load

// ### dv/soswt_asserts.sv
`timescale 1ns/1ps
module soswt_asserts #(
	parameter int NUM_OUT = soswt_pkg::NUM_OUT,
	parameter int DEADLINE_CYC = soswt_pkg::DEADLINE_CYC
) (
	input wire logic clk_in, sys_rst_in, peer_alarm_in,
	input wire logic [NUM_OUT-1:0] out_req_in, low_level_in,
	input wire logic [NUM_OUT-1:0] out_en_out, xreadback_out,
	input wire logic alarm_out, test_pass_out, test_active_out
);
	// cycles spent with a test holding an output off
	int tcnt;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tcnt <= 0;
		end else if (test_active_out) begin
			tcnt <= tcnt + 1;
		end else begin
			tcnt <= 0;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	xrb_copy_a: assert property (xreadback_out == $past(out_en_out))
		else $error("readback");
	alarm_off_a: assert property (alarm_out |-> out_en_out == 0)
		else $error("alarm drive");
	alarm_hold_a: assert property (alarm_out |=> alarm_out)
		else $error("alarm hold");
	off_start_a: assert property ($rose(test_active_out) |->
		out_en_out != $past(out_req_in)) else $error("test off");
	pass_cause_a: assert property (test_pass_out |->
		$past(test_active_out) && $past(low_level_in) != 0) else $error("pass");
	deadline_a: assert property (tcnt <= DEADLINE_CYC)
		else $error("deadline");
	pass_on_a: assert property (test_pass_out |->
		!test_active_out && out_en_out == $past(out_req_in))
		else $error("re-enable");
endmodule // soswt_asserts
bind soswt_top soswt_asserts #(.NUM_OUT(NUM_OUT), .DEADLINE_CYC(DEADLINE_CYC))
	u_chk (.*);

// ### dv/soswt_top_tb.sv
`timescale 1ns/1ps
module soswt_top_tb;
	logic clk_in = 0, rst = 1, pa = 0, st = 0, al, tp, ta;
	logic [3:0] rq = 4'h0, lv, en, xr, e0;
	logic seen;
	int failures = 0, tests_run = 0, cyc = 0, w;
	localparam int TP = 20;
	localparam int DL = 10;
	always #10 clk_in = ~clk_in;
	soswt_top #(.TEST_PERIOD_CYC(TP), .DEADLINE_CYC(DL)) dut (.clk_in(clk_in),
		.sys_rst_in(rst), .out_req_in(rq), .low_level_in(lv),
		.peer_alarm_in(pa), .out_en_out(en), .xreadback_out(xr),
		.alarm_out(al), .test_pass_out(tp), .test_active_out(ta));
	soswt_load load (.clk_in(clk_in), .en_in(en), .stuck_in(st), .low_out(lv));
	task chk(input logic c);
		tests_run++;
		if (c !== 1'b1) begin
			failures++;
			$display("Error %0t mismatch", $time);
		end
	endtask
	task final_report;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ceiling far above the fewer than two hundred cycles the tests need
	always @(posedge clk_in) if (++cyc == 3000) begin
		failures++;
		final_report;
	end
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task wait_test;
		w = 0;
		while (ta !== 1'b1 && w < 40) begin
			tick(1);
			w++;
		end
		chk(w < 40 && en !== 4'hF);
	endtask
	task good_tests;
		for (int i = 0; i < 4; i++) begin
			wait_test;
			e0 = en;
			tick(1);
			chk(xr === e0);
			w = 0;
			while (tp !== 1'b1 && w < 10) begin
				tick(1);
				w++;
			end
			chk(w < 10 && en === 4'hF && ta === 1'b0);
			tick(1);
		end
	endtask
	task stuck_test;
		st = 1;
		wait_test;
		w = 0;
		seen = 0;
		while (al !== 1'b1 && w < 40) begin
			tick(1);
			w++;
			if (tp === 1'b1) seen = 1;
		end
		chk(seen === 1'b0);
		chk(w == DL && en === 4'h0 && ta === 1'b0);
		chk(al === 1'b1 && en === 4'h0);
		tick(30);
		chk(al === 1'b1 && en === 4'h0);
		st = 0;
	endtask
	task peer_test;
		rst = 1;
		tick(6);
		rst = 0;
		tick(2);
		chk(al === 1'b0 && en === 4'hF);
		pa = 1;
		tick(1);
		pa = 0;
		chk(al === 1'b1 && en === 4'h0);
		tick(1);
		chk(al === 1'b1 && en === 4'h0);
	endtask
	initial begin
		tick(6);
		rst = 0;
		rq = 4'hF;
		good_tests;
		stuck_test;
		peer_test;
		final_report;
	end
endmodule // soswt_top_tb
